/* File: dv/eih_properties.sv */
`default_nettype none
`include "eih_cfg.svh"
module eih_properties
  import eih_pkg::*;
#(
  parameter logic [15:4] DEC_BASE = `EIH_DEC_BASE
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic address_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic aen_qualifier,
  input wire eih_addr_t io_address_lines,
  input wire logic byte_lane0_enable_n,
  input wire logic byte_lane1_enable_n,
  input wire eih_lane_t host_data_oe,
  input wire eih_lane_t dev_data_oe,
  input wire logic local_decode_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hit;
  eih_lane_t en;
  assign hit = io_address_lines[15:4] == DEC_BASE && !aen_qualifier;
  assign en = ~{byte_lane1_enable_n, byte_lane0_enable_n};
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // ***********
  // properties
  // ***********
  a_start_then_cmd:
    assert property ($rose(address_strobe_n) |-> !read_strobe_n ||
      !write_strobe_n) else $error("no strobe after start");
  a_rd_strobe_width:
    assert property ($fell(read_strobe_n) |-> ##18 $rose(read_strobe_n))
    else $error("read strobe width");
  a_wr_strobe_width:
    assert property ($fell(write_strobe_n) |-> ##18 $rose(write_strobe_n))
    else $error("write strobe width");
  a_addr_held:
    assert property (!read_strobe_n ##1 !read_strobe_n |->
      $stable(io_address_lines) && $stable(aen_qualifier))
    else $error("address moved in strobe");
  a_oe_lanes:
    assert property (!read_strobe_n && dev_data_oe != 2'h0 |->
      dev_data_oe == en) else $error("wrong lanes driven");
  a_oe_on_hit:
    assert property ($fell(read_strobe_n) && hit && en != 2'h0 |->
      ##[3:4] dev_data_oe == en) else $error("no drive on hit");
  a_miss_quiet:
    assert property ($fell(read_strobe_n) && !hit |->
      ##1 (dev_data_oe == 2'h0) [*8]) else $error("drive on miss");
  a_oe_release:
    assert property ($rose(read_strobe_n) |-> ##4 dev_data_oe == 2'h0)
    else $error("drive held too long");
  a_decode_out:
    assert property ($fell(read_strobe_n) || $fell(write_strobe_n) |->
      ##5 local_decode_n == !hit) else $error("local decode wrong");
  a_host_lanes:
    assert property ($fell(write_strobe_n) |-> host_data_oe == en)
    else $error("host write lanes");
  a_reset_idle:
    assert property (disable iff (1'b0) sys_rst |=> address_strobe_n &&
      read_strobe_n && write_strobe_n && dev_data_oe == 2'h0)
    else $error("not idle in reset");
endmodule
`default_nettype wire

/* File: dv/eih_tb.sv */
`default_nettype none
`include "eih_cfg.svh"
module eih_tb
  import eih_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic req_valid = 1'h0;
  logic req_write = 1'h0;
  logic req_mem_space = 1'h0;
  logic req_aen = 1'h0;
  logic irq_level = 1'h0;
  eih_addr_t req_addr = 14'h0;
  eih_lane_t req_be_n = 2'h0;
  eih_data_t req_wdata = 16'h0;
  eih_data_t rd_data = 16'h0;
  logic req_ready, rsp_valid, irq_rise, nows_n, rd_req, wr_valid;
  eih_data_t rsp_rdata, wr_data, got_d;
  eih_addr_t rd_addr, wr_addr, got_a;
  eih_lane_t rd_lanes, wr_lanes, got_l;
  logic [15:0] rsp_at, wr_at, strobe_len;
  logic got_rd, nows_bad, nows_seen;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam eih_addr_t HIT = {`EIH_DEC_BASE, 2'h1};
  always #5 clock = ~clock;
  eih_if u_eih_if();
  eih_host u_eih_host (.clock(clock), .sys_rst(sys_rst),
    .bus(u_eih_if.host), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_be_n(req_be_n), .req_wdata(req_wdata),
    .req_mem_space(req_mem_space), .req_aen(req_aen),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .irq_rise(irq_rise), .nows_n(nows_n));
  eih_device u_eih_device (.clock(clock), .sys_rst(sys_rst),
    .bus(u_eih_if.device), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_lanes(rd_lanes), .rd_data(rd_data), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_lanes(wr_lanes),
    .irq_level(irq_level));
  eih_properties u_eih_properties (.clock(clock), .sys_rst(sys_rst),
    .address_strobe_n(u_eih_if.address_strobe_n),
    .read_strobe_n(u_eih_if.read_strobe_n),
    .write_strobe_n(u_eih_if.write_strobe_n),
    .aen_qualifier(u_eih_if.aen_qualifier),
    .io_address_lines(u_eih_if.io_address_lines),
    .byte_lane0_enable_n(u_eih_if.byte_lane0_enable_n),
    .byte_lane1_enable_n(u_eih_if.byte_lane1_enable_n),
    .host_data_oe(u_eih_if.host_data_oe),
    .dev_data_oe(u_eih_if.dev_data_oe),
    .local_decode_n(u_eih_if.local_decode_n));
  // ***********
  // helpers
  // ***********
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic access(input logic w, input eih_addr_t a,
      input eih_lane_t be, input eih_data_t d, input logic mem,
      input logic aen);
    int n;
    logic [1:0] s;
    n = 0;
    while (req_ready !== 1'h1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    check("req_ready", {15'h0, req_ready}, 16'h1);
    {req_valid, req_write, req_mem_space, req_aen} = {1'h1, w, mem, aen};
    {req_addr, req_be_n, req_wdata} = {a, be, d};
    @(negedge clock);
    req_valid = 1'h0;
    {rsp_at, wr_at, got_rd, nows_bad} = {16'h0, 16'h0, 1'h0, 1'h0};
    {strobe_len, nows_seen} = {16'h0, 1'h0};
    for (int i = 0; i <= 26; i++) begin
      s = {u_eih_if.read_strobe_n, u_eih_if.write_strobe_n};
      if (i == 3) begin
        check("strobe_dir", 16'(s), {14'h0, w, !w});
      end
      if (s != 2'h3) begin
        strobe_len++;
      end
      if (i < 3 && nows_n === 1'h0) begin
        nows_seen = 1'h1;
      end
      if (rsp_valid === 1'h1) begin
        rsp_at = 16'(i);
        got_d = rsp_rdata;
      end
      if (rd_req === 1'h1) begin
        got_rd = 1'h1;
        {got_a, got_l} = {rd_addr, rd_lanes};
      end
      if (wr_valid === 1'h1) begin
        wr_at = 16'(i);
        {got_a, got_l, got_d} = {wr_addr, wr_lanes, wr_data};
      end
      if (i >= 3 && i <= 20 && nows_n !== 1'h1) begin
        nows_bad = 1'h1;
      end
      @(negedge clock);
    end
  endtask
  task automatic check_idle(input logic [15:0] oe);
    check("strobes", {12'h0, u_eih_if.address_strobe_n,
      u_eih_if.read_strobe_n, u_eih_if.write_strobe_n,
      u_eih_if.local_decode_n}, 16'hf);
    check("oe_ready", {13'h0, u_eih_if.dev_data_oe, req_ready}, oe);
  endtask
  // ***********
  // scenarios
  // ***********
  task automatic sc_read(input eih_lane_t be);
    rd_data = 16'ha55a;
    access(1'h0, HIT, be, 16'h0, 1'h0, 1'h0);
    check("rdata", got_d, {be[1] ? 8'hff : 8'ha5, be[0] ? 8'hff : 8'h5a});
    check("rsp_at", rsp_at, 16'h15);
    check("strobe_len", strobe_len, 16'(`EIH_CMD_CYC));
    check("nows", {15'h0, nows_bad}, 16'h0);
    if (be != 2'h3) begin
      check("rd_addr", {2'h0, got_a}, {2'h0, HIT});
      check("rd_lanes", {14'h0, got_l}, {14'h0, ~be});
    end
  endtask
  task automatic sc_write(input eih_lane_t be);
    access(1'h1, HIT, be, 16'h3cc3, 1'h0, 1'h0);
    check("nows_low", {15'h0, nows_seen}, 16'h1);
    if (be != 2'h3) begin
      check("wr_at", wr_at, 16'h18);
      check("wdata", got_d, {be[1] ? 8'h00 : 8'h3c, be[0] ? 8'h00 : 8'hc3});
      check("wr_addr", {2'h0, got_a}, {2'h0, HIT});
      check("wr_lanes", {14'h0, got_l}, {14'h0, ~be});
    end
  endtask
  task automatic sc_miss();
    access(1'h0, HIT, 2'h0, 16'h0, 1'h0, 1'h1);
    check("aen_rd", {got_rd, rsp_at[14:0]}, 16'h15);
    check("aen_data", got_d, 16'hffff);
    access(1'h1, HIT, 2'h0, 16'h1234, 1'h1, 1'h0);
    check("mem_wr", wr_at, 16'h0);
    access(1'h0, HIT ^ 14'h10, 2'h0, 16'h0, 1'h0, 1'h0);
    check("addr_rd", {15'h0, got_rd}, 16'h0);
  endtask
  task automatic sc_irq();
    int n;
    n = 0;
    irq_level = 1'h1;
    repeat (8) begin
      @(negedge clock);
      n += int'(irq_rise === 1'h1);
    end
    check("irq_pulses", 16'(n), 16'h1);
    check("irq_out", {15'h0, u_eih_if.interrupt_request_out}, 16'h1);
    irq_level = 1'h0;
    repeat (8) @(negedge clock);
    check("irq_low", {15'h0, u_eih_if.interrupt_request_out}, 16'h0);
  endtask
  task automatic sc_reset_mid();
    {req_valid, req_write, req_addr, req_be_n} = {2'h2, HIT, 2'h0};
    @(negedge clock);
    req_valid = 1'h0;
    repeat (10) @(negedge clock);
    sys_rst = 1'h1;
    repeat (3) @(negedge clock);
    check_idle(16'h0);
    sys_rst = 1'h0;
  endtask
  initial begin
    repeat (19) @(negedge clock);
    check_idle(16'h0);
    @(negedge clock);
    sys_rst = 1'h0;
    for (int b = 0; b < 4; b++) begin
      sc_read(2'(b));
      sc_write(2'(b));
    end
    sc_miss();
    sc_irq();
    sc_reset_mid();
    sc_read(2'h0);
    end_of_test();
  end
endmodule
`default_nettype wire

/* File: logic/eih_cfg.svh */
`ifndef EIH_CFG_SVH
`define EIH_CFG_SVH
`define EIH_CLK_NS 10
`define EIH_ACCESS_NS 180
`define EIH_CMD_CYC ((`EIH_ACCESS_NS + `EIH_CLK_NS - 1) / `EIH_CLK_NS)
`define EIH_START_CYC 3
`define EIH_RECOV_CYC 3
`define EIH_CNT_W 5
`define EIH_ADDR_MSB 15
`define EIH_ADDR_LSB 2
`define EIH_DEC_LSB 4
`define EIH_DATA_W 16
`define EIH_LANE_W 8
`define EIH_LANES 2
`define EIH_SYNC_IDLE 1'b1
`define EIH_BUS_IDLE 8'hff
`define EIH_DEC_BASE 12'h030
`endif

/* File: logic/eih_device.sv */
`default_nettype none
`include "eih_cfg.svh"
// Contract
// RULE1: 16-bit I/O slave, strobe-timed, no bus clock
// RULE2: glue makes strobes from command and direction
// RULE3: access long enough, no wait states needed
// RULE4: capture IO_ADDRESS_LINES at address strobe trailing edge
// RULE5: glue ORs memory/IO with AEN into qualifier
// RULE6: qualifier transparent while strobe low, held after
// RULE7: host sets address before each strobe
// RULE8: write data captured at write strobe rise
// RULE9: byte enables captured at address strobe rise
// RULE10: interrupt output active high, edge triggered
// RULE11: 16-bit data, lanes chosen by byte enables
// RULE12: local decode active on A15-A4 match, AEN low
// RULE13: no-wait request inactive at start rise
// RULE14: compressed cycles: 1.5 clocks, half-clock strobe; host only runs full-length cycles with an 18-clock strobe
// RULE15: address strobe wired straight to start
// RULE16: reset holds the port idle
module eih_device
  import eih_pkg::*;
#(
  parameter logic [`EIH_ADDR_MSB:`EIH_DEC_LSB] DEC_BASE = `EIH_DEC_BASE
) (
  input wire logic clock,
  input wire logic sys_rst,
  eih_if.device bus,
  output logic rd_req,
  output eih_addr_t rd_addr,
  output eih_lane_t rd_lanes,
  input wire eih_data_t rd_data,
  output logic wr_valid,
  output eih_addr_t wr_addr,
  output eih_data_t wr_data,
  output eih_lane_t wr_lanes,
  input wire logic irq_level
);
  localparam int AW = `EIH_ADDR_MSB - `EIH_ADDR_LSB + 1;
  localparam int SW = 4 + `EIH_LANES + AW + `EIH_DATA_W;

  // ***********************
  // decode helpers
  // ***********************
  function automatic logic decode_hit(eih_addr_t a, logic q);
    decode_hit = (a[`EIH_ADDR_MSB:`EIH_DEC_LSB] == DEC_BASE) && !q;
  endfunction

  // active-low enables to active-high lane mask
  function automatic eih_lane_t lane_mask(eih_lane_t be_n);
    lane_mask = ~be_n;
  endfunction

  // ***********************
  // pin synchronisers
  // ***********************
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_s;
  logic ads_s;
  logic rd_s;
  logic wr_s;
  logic aen_s;
  eih_lane_t be_s;
  eih_addr_t addr_s;
  eih_data_t data_s;

  assign pin_raw = {bus.address_strobe_n, bus.read_strobe_n,
                    bus.write_strobe_n, bus.aen_qualifier,
                    bus.byte_lane1_enable_n, bus.byte_lane0_enable_n,
                    bus.io_address_lines, bus.data_bus};

  eih_sync #(
    .W(SW)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(pin_raw),
    .q(pin_s)
  );

  assign {ads_s, rd_s, wr_s, aen_s, be_s, addr_s, data_s} = pin_s;

  // ***********************
  // strobe edges
  // ***********************
  logic rd_d_reg;
  logic wr_d_reg;
  logic rd_fall;
  logic wr_fall;
  logic wr_rise;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_d_reg <= 1'b1;
      wr_d_reg <= 1'b1;
    end else begin
      rd_d_reg <= rd_s;
      wr_d_reg <= wr_s;
    end
  end

  // timing taken from strobes only
  assign rd_fall = rd_d_reg && !rd_s; // see RULE1
  assign wr_fall = wr_d_reg && !wr_s; // see RULE1
  assign wr_rise = !wr_d_reg && wr_s;

  // ***********************
  // address phase latch
  // ***********************
  eih_addr_t addr_lat_reg;
  logic aen_lat_reg;
  eih_lane_t be_lat_reg;
  logic hit;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_lat_reg <= '0;
      aen_lat_reg <= 1'b1;
      be_lat_reg <= '1;
    end else if (!ads_s) begin
      addr_lat_reg <= addr_s; // see RULE4
      aen_lat_reg <= aen_s; // see RULE6
      be_lat_reg <= be_s; // see RULE9
    end
  end

  assign hit = decode_hit(addr_lat_reg, aen_lat_reg);

  // ***********************
  // local decode output
  // ***********************
  logic ldev_n_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ldev_n_reg <= 1'b1;
    end else begin
      ldev_n_reg <= !hit; // see RULE12
    end
  end

  // ***********************
  // access state machine
  // ***********************
  eih_dev_state_e state_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= DEV_IDLE; // see RULE16
    end else begin
      case (state_reg)
        DEV_IDLE: begin
          if (rd_fall && hit) begin
            state_reg <= DEV_READ;
          end else if (wr_fall && hit) begin
            state_reg <= DEV_WRITE;
          end
        end
        DEV_READ: begin
          if (rd_s) begin
            state_reg <= DEV_IDLE;
          end
        end
        DEV_WRITE: begin
          if (wr_rise) begin
            state_reg <= DEV_IDLE;
          end
        end
        default: begin
          state_reg <= DEV_IDLE;
        end
      endcase
    end
  end

  // ***********************
  // read path
  // ***********************
  logic rd_req_reg;
  eih_addr_t rd_addr_reg;
  eih_lane_t rd_lanes_reg;
  eih_data_t data_out_reg;
  eih_lane_t data_oe_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_req_reg <= 1'b0;
      rd_addr_reg <= '0;
      rd_lanes_reg <= '0;
    end else begin
      rd_req_reg <= (state_reg == DEV_IDLE) && rd_fall && hit;
      if ((state_reg == DEV_IDLE) && rd_fall && hit) begin
        rd_addr_reg <= addr_lat_reg;
        rd_lanes_reg <= lane_mask(be_lat_reg); // see RULE11
      end
    end
  end

  // unused lanes stay undriven
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      data_out_reg <= '0;
      data_oe_reg <= '0;
    end else if (state_reg == DEV_READ && !rd_s) begin
      data_out_reg <= rd_data;
      data_oe_reg <= rd_lanes_reg; // see RULE11
    end else begin
      data_oe_reg <= '0;
    end
  end

  // ***********************
  // write path
  // ***********************
  eih_data_t wr_cap_reg;
  logic wr_valid_reg;
  eih_addr_t wr_addr_reg;
  eih_data_t wr_data_reg;
  eih_lane_t wr_lanes_reg;
  eih_lane_t wr_mask;

  assign wr_mask = lane_mask(be_lat_reg);

  // follows the bus while strobe low, last value kept at rise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_cap_reg <= '0;
    end else if (!wr_s) begin
      wr_cap_reg <= data_s; // see RULE8
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_valid_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_lanes_reg <= '0;
    end else begin
      wr_valid_reg <= (state_reg == DEV_WRITE) && wr_rise; // see RULE8
      if ((state_reg == DEV_WRITE) && wr_rise) begin
        wr_addr_reg <= addr_lat_reg;
        wr_lanes_reg <= wr_mask;
        for (int i = 0; i < `EIH_LANES; i++) begin
          // ignored lanes passed to wr_data as zero
          wr_data_reg[i*`EIH_LANE_W +: `EIH_LANE_W] <= wr_mask[i] ?
            wr_cap_reg[i*`EIH_LANE_W +: `EIH_LANE_W] : '0; // see RULE11
        end
      end
    end
  end

  // ***********************
  // interrupt
  // ***********************
  logic irq_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_level; // see RULE10
    end
  end

  // ***********************
  // outputs
  // ***********************
  assign bus.dev_data_out = data_out_reg;
  assign bus.dev_data_oe = data_oe_reg;
  assign bus.local_decode_n = ldev_n_reg;
  assign bus.interrupt_request_out = irq_reg;
  assign rd_req = rd_req_reg;
  assign rd_addr = rd_addr_reg;
  assign rd_lanes = rd_lanes_reg;
  assign wr_valid = wr_valid_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
  assign wr_lanes = wr_lanes_reg;
endmodule
`default_nettype wire

/* File: logic/eih_host.sv */
`default_nettype none
`include "eih_cfg.svh"
module eih_host
  import eih_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  eih_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire eih_addr_t req_addr,
  input wire eih_lane_t req_be_n,
  input wire eih_data_t req_wdata,
  input wire logic req_mem_space,
  input wire logic req_aen,
  output logic req_ready,
  output logic rsp_valid,
  output eih_data_t rsp_rdata,
  output logic irq_rise,
  output logic nows_n
);
  localparam int SW = `EIH_DATA_W + 2;

  // ***********************
  // pin synchronisers
  // ***********************
  logic [SW-1:0] pin_s;
  eih_data_t data_s;
  logic ldev_s;
  logic irq_s;
  logic irq_d_reg;

  eih_sync #(
    .W(SW)
  ) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d({bus.data_bus, bus.local_decode_n, bus.interrupt_request_out}),
    .q(pin_s)
  );

  assign {data_s, ldev_s, irq_s} = pin_s;

  // ***********************
  // bus cycle sequencer
  // ***********************
  eih_hst_state_e state_reg;
  logic [`EIH_CNT_W-1:0] cnt_reg;
  logic write_reg;
  logic ads_n_reg;
  logic rd_n_reg;
  logic wr_n_reg;
  logic aen_q_reg;
  eih_addr_t addr_reg;
  eih_lane_t be_n_reg;
  eih_data_t dout_reg;
  eih_lane_t doe_reg;
  logic ready_reg;
  logic rsp_valid_reg;
  eih_data_t rdata_reg;
  logic nows_n_reg;
  logic irq_rise_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= HST_IDLE;
      cnt_reg <= '0;
      write_reg <= 1'b0;
      ads_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      aen_q_reg <= 1'b1;
      addr_reg <= '0;
      be_n_reg <= '1;
      dout_reg <= '0;
      doe_reg <= '0;
      ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rdata_reg <= '0;
      nows_n_reg <= 1'b1;
    end else begin
      rsp_valid_reg <= 1'b0;
      case (state_reg)
        HST_IDLE: begin
          ready_reg <= 1'b1;
          if (req_valid && ready_reg) begin
            ready_reg <= 1'b0;
            write_reg <= req_write;
            addr_reg <= req_addr; // see RULE7
            be_n_reg <= req_be_n;
            dout_reg <= req_wdata;
            aen_q_reg <= req_mem_space | req_aen; // see RULE5
            ads_n_reg <= 1'b0; // see RULE15
            cnt_reg <= `EIH_CNT_W'(`EIH_START_CYC - 1);
            state_reg <= HST_START;
          end
        end
        HST_START: begin
          nows_n_reg <= ldev_s;
          if (cnt_reg == '0) begin
            ads_n_reg <= 1'b1;
            nows_n_reg <= 1'b1; // see RULE13
            rd_n_reg <= write_reg; // see RULE2
            wr_n_reg <= !write_reg; // see RULE2
            doe_reg <= write_reg ? ~be_n_reg : '0;
            // strobe long enough, no ready handshake
            cnt_reg <= `EIH_CNT_W'(`EIH_CMD_CYC - 1); // see RULE3
            state_reg <= HST_CMD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        HST_CMD: begin
          if (cnt_reg == '0) begin
            rd_n_reg <= 1'b1;
            wr_n_reg <= 1'b1;
            if (!write_reg) begin
              rdata_reg <= data_s;
              rsp_valid_reg <= 1'b1;
            end
            cnt_reg <= `EIH_CNT_W'(`EIH_RECOV_CYC - 1);
            state_reg <= HST_RECOV;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        HST_RECOV: begin
          if (cnt_reg == '0) begin
            doe_reg <= '0;
            aen_q_reg <= 1'b1;
            state_reg <= HST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= HST_IDLE;
        end
      endcase
    end
  end

  // ***********************
  // interrupt edge
  // ***********************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_d_reg <= 1'b0;
      irq_rise_reg <= 1'b0;
    end else begin
      irq_d_reg <= irq_s;
      irq_rise_reg <= irq_s && !irq_d_reg; // see RULE10
    end
  end

  // ***********************
  // outputs
  // ***********************
  assign bus.address_strobe_n = ads_n_reg;
  assign bus.read_strobe_n = rd_n_reg;
  assign bus.write_strobe_n = wr_n_reg;
  assign bus.aen_qualifier = aen_q_reg;
  assign bus.io_address_lines = addr_reg;
  assign bus.byte_lane0_enable_n = be_n_reg[0];
  assign bus.byte_lane1_enable_n = be_n_reg[1];
  assign bus.host_data_out = dout_reg;
  assign bus.host_data_oe = doe_reg;
  assign req_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rdata_reg;
  assign irq_rise = irq_rise_reg;
  assign nows_n = nows_n_reg;
endmodule
`default_nettype wire

/* File: logic/eih_if.sv */
`default_nettype none
`include "eih_cfg.svh"
interface eih_if;
  import eih_pkg::*;
  logic address_strobe_n;
  logic read_strobe_n;
  logic write_strobe_n;
  logic aen_qualifier;
  eih_addr_t io_address_lines;
  logic byte_lane0_enable_n;
  logic byte_lane1_enable_n;
  eih_data_t host_data_out;
  eih_lane_t host_data_oe;
  eih_data_t dev_data_out;
  eih_lane_t dev_data_oe;
  eih_data_t data_bus;
  logic interrupt_request_out;
  logic local_decode_n;

  // ***********************
  // wire level per lane
  // ***********************
  for (genvar i = 0; i < `EIH_LANES; i++) begin : g_lane
    assign data_bus[i*`EIH_LANE_W +: `EIH_LANE_W] =
      dev_data_oe[i] ? dev_data_out[i*`EIH_LANE_W +: `EIH_LANE_W] :
      host_data_oe[i] ? host_data_out[i*`EIH_LANE_W +: `EIH_LANE_W] :
      `EIH_BUS_IDLE;
  end

  modport device (
    input address_strobe_n, read_strobe_n, write_strobe_n,
    input aen_qualifier, io_address_lines,
    input byte_lane0_enable_n, byte_lane1_enable_n, data_bus,
    output dev_data_out, dev_data_oe,
    output interrupt_request_out, local_decode_n
  );
  modport host (
    output address_strobe_n, read_strobe_n, write_strobe_n,
    output aen_qualifier, io_address_lines,
    output byte_lane0_enable_n, byte_lane1_enable_n,
    output host_data_out, host_data_oe,
    input data_bus, interrupt_request_out, local_decode_n
  );
endinterface
`default_nettype wire

/* File: logic/eih_pkg.sv */
`default_nettype none
`include "eih_cfg.svh"
package eih_pkg;
  typedef logic [`EIH_ADDR_MSB:`EIH_ADDR_LSB] eih_addr_t;
  typedef logic [`EIH_DATA_W-1:0] eih_data_t;
  typedef logic [`EIH_LANES-1:0] eih_lane_t;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h1,
    DEV_READ = 3'h2,
    DEV_WRITE = 3'h4
  } eih_dev_state_e;
  typedef enum logic [3:0] {
    HST_IDLE = 4'h1,
    HST_START = 4'h2,
    HST_CMD = 4'h4,
    HST_RECOV = 4'h8
  } eih_hst_state_e;
endpackage
`default_nettype wire

/* File: logic/eih_sync.sv */
`default_nettype none
`include "eih_cfg.svh"
module eih_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // two flops, first one read only by the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= {W{`EIH_SYNC_IDLE}};
      sync_reg <= {W{`EIH_SYNC_IDLE}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule
`default_nettype wire
